// ==== bench/smbus_host_model.sv ====
// Host master model driving open-drain SMBus lines
`default_nettype none
module smbus_host_model (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_pull_o,
   output logic      sda_pull_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
   end
   // Waits out a slave clock stretch, bounded
   task automatic hi();
      scl_pull_o = 1'b0;
      for (int n = 0; n < 4000 && scl_i !== 1'b1; n++) #40;
      #160;
   endtask
   // Hold after the fall keeps SDA edges clear of SCL high
   task automatic bt(input logic b, output logic r);
      sda_pull_o = ~b;
      #120;
      hi();
      r = sda_i;
      scl_pull_o = 1'b1;
      #40;
   endtask
   task automatic start();
      sda_pull_o = 1'b0;
      #160;
      hi();
      sda_pull_o = 1'b1;
      #160;
      scl_pull_o = 1'b1;
      #40;
   endtask
   task automatic stop();
      sda_pull_o = 1'b1;
      #160;
      hi();
      sda_pull_o = 1'b0;
      #160;
   endtask
   task automatic wb(input logic [7:0] d, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) bt(d[i], r);
      bt(1'b1, r);
      a = ~r;
   endtask
   task automatic rb(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bt(1'b1, d[i]);
      bt(nack, r);
   endtask
endmodule
`default_nettype wire

// ==== bench/tb_smbus_slave_register_port.sv ====
// Self-checking bench for the SMBus slave register port
`default_nettype none
module tb_smbus_slave_register_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic                     sys_clk_i = 1'b0;
   logic                     rstn_i = 1'b0;
   logic                     rdy = 1'b1;
   logic                     ak, scl_oe, sda_oe, scl_o, sda_o, mscl, msda, wv, done;
   logic [7:0]               ra, d;
   smbus_port_pkg::wr_beat_t wb;
   wire logic                scl = ~(mscl | (scl_oe & ~scl_o));
   wire logic                sda = ~(msda | (sda_oe & ~sda_o));
   int                       errors = 0, n_compared = 0, dn = 0, cyc = 0, d0;
   logic [15:0]              q[$];
   logic [7:0]               rq[$];
   smbus_slave_register_port #(.TIMEOUT_CYC(200)) dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl),
      .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_i(2'h1),
      .wr_valid_o(wv), .wr_ready_i(rdy), .wr_beat_o(wb), .rd_addr_o(ra), .rd_data_i(ra ^ 8'h5A), .rd_done_o(done));
   smbus_host_model m_u (.scl_i(scl), .sda_i(sda), .scl_pull_o(mscl), .sda_pull_o(msda));
   initial forever #20 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cyc++;
      if (wv && rdy) q.push_back(wb);
      if (done) dn++;
      if (cyc == 40000) begin
         errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic w(input logic [7:0] b);
      m_u.wb(b, ak);
      chk(ak, 1'b1);
   endtask
   task automatic txn(input logic [7:0] bs[$]);
      m_u.start();
      foreach (bs[i]) w(bs[i]);
      m_u.stop();
   endtask
   task automatic rd(input logic sc, input logic [7:0] c, input int n);
      rq.delete();
      m_u.start();
      if (sc) begin
         txn_cmd(c);
      end
      w(8'h5B);
      for (int i = 0; i < n; i++) begin
         m_u.rb(i == n - 1, d);
         rq.push_back(d);
      end
      m_u.stop();
   endtask
   task automatic txn_cmd(input logic [7:0] c);
      w(8'h5A);
      w(c);
      m_u.start();
   endtask
   task automatic ended(input string s);
      repeat (20) @(negedge sys_clk_i);
      $display("test %s done", s);
   endtask
   // Buffer fills during the word; the third beat must stretch SCL until ready
   task automatic t_write();
      rdy = 1'b0;
      fork
         begin
            repeat (900) @(negedge sys_clk_i);
            rdy = 1'b1;
         end
      join_none
      txn('{8'h5A, 8'h20, 8'h11, 8'h22});
      txn('{8'h5A, 8'hEF, 8'h3C});
      txn('{8'h5A, 8'hF0, 8'h03, 8'h10, 8'hAA, 8'hBB});
      ended("write");
      chk(q.pop_front(), 16'h2011);
      chk(q.pop_front(), 16'h2122);
      chk(q.pop_front(), 16'hEF3C);
      chk(q.pop_front(), 16'h10AA);
      chk(q.pop_front(), 16'h11BB);
   endtask
   task automatic t_read();
      d0 = dn;
      rd(1'b1, 8'h33, 1);
      chk(rq[0], 8'h69);
      rd(1'b0, 8'h00, 1);
      chk(rq[0], 8'h69);
      ended("read");
      chk(dn - d0, 2);
   endtask
   task automatic t_fixed();
      logic [7:0] ln[12] = '{8'h08, 8'h08, 8'h06, 8'h10, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h08, 8'h08, 8'h10, 8'h09};
      logic [7:0] bs[12] = '{8'h40, 8'h48, 8'h50, 8'h56, 8'h67, 8'h6E, 8'h78, 8'h90, 8'hB4, 8'hC8, 8'hD0, 8'hE5};
      for (int k = 0; k < 12; k++) begin
         rd(1'b1, 8'(8'hF2 + k), 2);
         chk({rq[0], rq[1]}, {ln[k], bs[k] ^ 8'h5A});
      end
      ended("fixed");
   endtask
   // Read of 30h gives 6Ah, so SDA is free for the STOP after four bits
   task automatic t_abort();
      m_u.start();
      txn_cmd(8'h30);
      w(8'h5A);
      repeat (4) m_u.bt(1'b0, ak);
      m_u.stop();
      d0 = dn;
      m_u.start();
      w(8'h5B);
      repeat (4) m_u.bt(1'b1, ak);
      m_u.stop();
      ended("abort");
      chk(q.size(), 0);
      chk(dn, d0);
   endtask
   task automatic t_refuse();
      m_u.start();
      m_u.wb(8'h5E, ak);
      chk(ak, 1'b0);
      m_u.stop();
      m_u.start();
      w(8'h5A);
      m_u.wb(8'hFE, ak);
      chk(ak, 1'b0);
      m_u.stop();
      ended("refuse");
   endtask
   // Both lines low past the limit; later bits without START must be ignored
   task automatic t_tout();
      m_u.start();
      repeat (300) @(negedge sys_clk_i);
      m_u.wb(8'h5A, ak);
      chk(ak, 1'b0);
      m_u.stop();
      ended("timeout");
   endtask
   initial begin
      repeat (2) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      t_write();
      t_read();
      t_fixed();
      t_abort();
      t_refuse();
      t_tout();
      complete_run();
   end
endmodule
`default_nettype wire

// ==== rtl/smbus_port_pkg.sv ====
// Shared constants, types and block table for the SMBus slave register port
`default_nettype none
package smbus_port_pkg;
   localparam logic [4:0] ADDR_HI     = 5'h0B;
   localparam logic [7:0] REG_LAST    = 8'hEF;
   localparam logic [7:0] CMD_BLK_WR  = 8'hF0;
   localparam logic [7:0] CMD_BLK_PC  = 8'hF1;
   localparam logic [7:0] CMD_FIX_LO  = 8'hF2;
   localparam logic [7:0] CMD_FIX_HI  = 8'hFD;
   localparam logic [7:0] BLK_MAX_LEN = 8'h20;
   localparam logic [7:0] IDLE_BYTE   = 8'hFF;
   localparam logic [3:0] BIT_LAST    = 4'h7;
   localparam logic [3:0] BIT_ACK     = 4'h8;
   localparam int unsigned CLK_MHZ      = 25;
   localparam int unsigned T_TIMEOUT_US = 25000;
   localparam int unsigned TIMEOUT_CYC  = T_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned FIFO_DEPTH   = 2;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } wr_beat_t;

   typedef struct packed {
      logic [7:0] base;
      logic [7:0] len;
   } blk_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_WR,
      ST_RD,
      ST_IGNORE
   } bus_state_t;

   typedef enum logic [1:0] {
      MODE_REG,
      MODE_BLOCK,
      MODE_FIXED,
      MODE_NONE
   } cmd_mode_t;

   function automatic blk_t fixed_block(input logic [7:0] cmd);
      blk_t b;
      b = '{base: 8'h00, len: 8'h00};
      unique case (cmd)
         8'hF2:   b = '{base: 8'h40, len: 8'h08};
         8'hF3:   b = '{base: 8'h48, len: 8'h08};
         8'hF4:   b = '{base: 8'h50, len: 8'h06};
         8'hF5:   b = '{base: 8'h56, len: 8'h10};
         8'hF6:   b = '{base: 8'h67, len: 8'h04};
         8'hF7:   b = '{base: 8'h6E, len: 8'h08};
         8'hF8:   b = '{base: 8'h78, len: 8'h0C};
         8'hF9:   b = '{base: 8'h90, len: 8'h20};
         8'hFA:   b = '{base: 8'hB4, len: 8'h08};
         8'hFB:   b = '{base: 8'hC8, len: 8'h08};
         8'hFC:   b = '{base: 8'hD0, len: 8'h10};
         8'hFD:   b = '{base: 8'hE5, len: 8'h09};
         default: b = '{base: 8'h00, len: 8'h00};
      endcase
      return b;
   endfunction
endpackage
`default_nettype wire

// ==== rtl/smbus_slave_register_port.sv ====
// SMBus slave front end: bit engine, command decode, write buffer and read path
//
// Contract
// - Either bus line low past the timeout returns the bus machine to idle.
// - Device reset pin does not touch the bus machine; timeout or START does.
// - Data held low recovers by timeout; otherwise the first START reinitialises.
// - START or STOP mid write byte discards it; nothing is written.
// - START or STOP mid read byte suppresses the clear-on-read side effect.
// - Register addresses 00h..EFh; codes F0h..FDh are block commands, FEh and FFh are refused.
// - Send, write byte/word, block writes, reads, block reads, process call accepted.
// - No packet error checking, alert response or other transactions.
// - Base pointer does not advance across reads, process call included.
// - F0h selects block write, F1h selects block write/read process call.
// - F2h 8 bytes at 40h; F3h 8 at 48h; F4h 6 at 50h.
// - F5h 16 bytes at 56h; F6h 4 at 67h; F7h 8 at 6Eh.
// - F8h 12 bytes at 78h; F9h 32 at 90h; FAh 8 at B4h.
// - FBh 8 bytes at C8h; FCh 16 at D0h; FDh 9 at E5h.
// - Write byte: address, command, one data byte, STOP; each byte acknowledged.
// - Write word: address, command, low byte, high byte, STOP; all acknowledged for commands below EFh.
// - Slave address upper five bits fixed, low two from select; latched once.
// - Block write: F0h, count up to 32, first data byte is start address.
`default_nettype none

module beat_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             clk_i,
   input  wire logic             rstn_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [DEPTH-1:0] vld_q;
   logic [DEPTH-1:0] vld_d;
   logic             pop;
   logic             push;
   logic             placed;

   // Head sits in entry 0 so out_valid_o and out_data_o are plain flops
   assign pop          = vld_q[0] & out_ready_i;
   assign in_ready_o   = ~vld_q[DEPTH-1] | out_ready_i;
   assign push         = in_valid_i & in_ready_o;
   assign out_valid_o  = vld_q[0];
   assign out_data_o   = mem_q[0];

   always_comb begin
      placed = 1'b0;
      vld_d  = vld_q;
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = mem_q[i];
      end
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            vld_d[i] = vld_q[i+1];
            mem_d[i] = mem_q[i+1];
         end
         vld_d[DEPTH-1] = 1'b0;
      end
      for (int i = 0; i < DEPTH; i++) begin
         if (push && !placed && !vld_d[i]) begin
            vld_d[i] = 1'b1;
            mem_d[i] = in_data_i;
            placed   = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         vld_q <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         vld_q <= vld_d;
         mem_q <= mem_d;
      end
   end
endmodule

module smbus_slave_register_port #(
   parameter int unsigned TIMEOUT_CYC = smbus_port_pkg::TIMEOUT_CYC
) (
   input  wire logic                     sys_clk_i,
   input  wire logic                     rstn_i,
   input  wire logic                     scl_i,
   output logic                          scl_o,
   output logic                          scl_oe_o,
   input  wire logic                     sda_i,
   output logic                          sda_o,
   output logic                          sda_oe_o,
   input  wire logic [1:0]               addr_sel_i,
   output logic                          wr_valid_o,
   input  wire logic                     wr_ready_i,
   output smbus_port_pkg::wr_beat_t      wr_beat_o,
   output logic [7:0]                    rd_addr_o,
   input  wire logic [7:0]               rd_data_i,
   output logic                          rd_done_o
);
   localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);

   logic [2:0]                  scl_sy_q, sda_sy_q;
   logic [1:0]                  sel_m_q, sel_s_q;
   logic                        scl_s, scl_p, sda_s, sda_p;
   logic                        scl_rise, scl_fall, start_det, stop_det;
   logic [TW-1:0]               tmo_cnt_q;
   logic                        tmo_hit;
   smbus_port_pkg::bus_state_t  state_q;
   smbus_port_pkg::cmd_mode_t   mode_q;
   logic [3:0]                  bit_cnt_q;
   logic [7:0]                  shift_q, tx_q, idx_q, rd_idx_q, ptr_q;
   logic [7:0]                  blk_base_q, blk_len_q;
   logic                        rw_q, pend_v_q, fifo_ready;
   smbus_port_pkg::wr_beat_t    pend_q, beat;
   logic                        addr_lat_q;
   logic [1:0]                  own_lsb_q;
   logic                        addr_match, byte_done, wr_ack, push_req;
   logic [8:0]                  wr_addr;
   logic [7:0]                  tx_byte;
   logic                        cmd_take;
   smbus_port_pkg::blk_t        fix;

   // Line sampling; stage 0 feeds only stage 1
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         scl_sy_q <= 3'h7;
         sda_sy_q <= 3'h7;
         sel_m_q  <= 2'h0;
         sel_s_q  <= 2'h0;
      end else begin
         scl_sy_q <= {scl_sy_q[1:0], scl_i};
         sda_sy_q <= {sda_sy_q[1:0], sda_i};
         sel_m_q  <= addr_sel_i;
         sel_s_q  <= sel_m_q;
      end
   end

   assign scl_s     = scl_sy_q[1];
   assign scl_p     = scl_sy_q[2];
   assign sda_s     = sda_sy_q[1];
   assign sda_p     = sda_sy_q[2];
   assign scl_rise  = scl_s & ~scl_p;
   assign scl_fall  = ~scl_s & scl_p;
   assign start_det = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_det  = scl_s & scl_p & ~sda_p & sda_s;

   // Own stretch excluded on both lines: our ACK holds SDA low meanwhile
   // Limitation: a line stuck during our stretch is seen once the buffer drains
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         tmo_cnt_q <= '0;
      end else if (~pend_v_q & (~scl_s | ~sda_s)) begin
         if (!tmo_hit) begin
            tmo_cnt_q <= tmo_cnt_q + TW'(1);
         end
      end else begin
         tmo_cnt_q <= '0;
      end
   end
   assign tmo_hit = (tmo_cnt_q == TW'(TIMEOUT_CYC - 1));

   assign byte_done = scl_fall && (bit_cnt_q == smbus_port_pkg::BIT_LAST);
   assign cmd_take  = byte_done && (state_q == smbus_port_pkg::ST_WR) && (idx_q == 8'h00) && !tmo_hit;
   assign fix       = smbus_port_pkg::fixed_block(shift_q);
   assign addr_match = (shift_q[7:3] == smbus_port_pkg::ADDR_HI) &&
                       (shift_q[2:1] == (addr_lat_q ? own_lsb_q : sel_s_q));

   // Decode of a completed write-direction byte
   always_comb begin
      wr_ack   = 1'b0;
      push_req = 1'b0;
      wr_addr  = 9'h000;
      if (idx_q == 8'h00) begin
         wr_ack = (shift_q < smbus_port_pkg::CMD_FIX_LO) ||
                  (shift_q <= smbus_port_pkg::CMD_FIX_HI);
      end else begin
         unique case (mode_q)
            smbus_port_pkg::MODE_REG: begin
               wr_addr  = {1'b0, ptr_q} + {1'b0, idx_q} - 9'h001;
               push_req = (wr_addr <= {1'b0, smbus_port_pkg::REG_LAST});
               wr_ack   = push_req;
            end
            smbus_port_pkg::MODE_BLOCK: begin
               if (idx_q == 8'h01) begin
                  wr_ack = (shift_q != 8'h00) && (shift_q <= smbus_port_pkg::BLK_MAX_LEN);
               end else if (idx_q == 8'h02) begin
                  wr_ack = (shift_q <= smbus_port_pkg::REG_LAST);
               end else begin
                  wr_addr  = {1'b0, blk_base_q} + {1'b0, idx_q} - 9'h003;
                  push_req = ((idx_q - 8'h02) < blk_len_q) &&
                             (wr_addr <= {1'b0, smbus_port_pkg::REG_LAST});
                  wr_ack   = push_req;
               end
            end
            default: wr_ack = 1'b0;
         endcase
      end
   end
   assign beat = '{addr: wr_addr[7:0], data: shift_q};

   // Slave address latched at the first upper-bit match, kept until power-off
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         addr_lat_q <= 1'b0;
         own_lsb_q  <= 2'h0;
      end else if (state_q == smbus_port_pkg::ST_ADDR && byte_done && !addr_lat_q && !tmo_hit &&
                   shift_q[7:3] == smbus_port_pkg::ADDR_HI) begin
         addr_lat_q <= 1'b1;
         own_lsb_q  <= sel_s_q;
      end
   end

   // Command byte: pointer, mode and block window
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         ptr_q      <= 8'h00;
         mode_q     <= smbus_port_pkg::MODE_REG;
         blk_base_q <= 8'h00;
         blk_len_q  <= 8'h00;
      end else if (cmd_take) begin
         if (shift_q < smbus_port_pkg::CMD_BLK_WR) begin
            ptr_q  <= shift_q;
            mode_q <= smbus_port_pkg::MODE_REG;
         end else if (shift_q <= smbus_port_pkg::CMD_BLK_PC) begin
            mode_q <= smbus_port_pkg::MODE_BLOCK;
         end else if (shift_q <= smbus_port_pkg::CMD_FIX_HI) begin
            mode_q     <= smbus_port_pkg::MODE_FIXED;
            blk_base_q <= fix.base;
            blk_len_q  <= fix.len;
         end else begin
            mode_q <= smbus_port_pkg::MODE_NONE;
         end
      end else if (byte_done && state_q == smbus_port_pkg::ST_WR && !tmo_hit &&
                   mode_q == smbus_port_pkg::MODE_BLOCK && wr_ack) begin
         if (idx_q == 8'h01) begin
            blk_len_q <= shift_q;
         end else if (idx_q == 8'h02) begin
            blk_base_q <= shift_q;
         end
      end
   end

   // Completed bytes wait here; SCL is held low until the buffer takes them
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         pend_v_q <= 1'b0;
         pend_q   <= '0;
      end else if (byte_done && state_q == smbus_port_pkg::ST_WR && push_req && !tmo_hit) begin
         pend_v_q <= 1'b1;
         pend_q   <= beat;
      end else if (fifo_ready) begin
         pend_v_q <= 1'b0;
      end
   end

   beat_fifo #(
      .WIDTH ($bits(smbus_port_pkg::wr_beat_t)),
      .DEPTH (smbus_port_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_i        (sys_clk_i),
      .rstn_i       (rstn_i),
      .in_valid_i   (pend_v_q),
      .in_ready_o   (fifo_ready),
      .in_data_i    (pend_q),
      .out_valid_o  (wr_valid_o),
      .out_ready_i  (wr_ready_i),
      .out_data_o   (wr_beat_o)
   );

   // Read byte source: count byte first for block reads
   assign tx_byte = (mode_q == smbus_port_pkg::MODE_NONE) ? smbus_port_pkg::IDLE_BYTE :
                    (mode_q != smbus_port_pkg::MODE_REG && rd_idx_q == 8'h00) ? blk_len_q : rd_data_i;

   // Bus machine; rstn_i is power-on only, the device reset pin never reaches it
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         state_q   <= smbus_port_pkg::ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         tx_q      <= 8'h00;
         idx_q     <= 8'h00;
         rd_idx_q  <= 8'h00;
         rw_q      <= 1'b0;
         sda_oe_o  <= 1'b0;
         rd_done_o <= 1'b0;
      end else begin
         rd_done_o <= 1'b0;
         if (tmo_hit) begin
            state_q  <= smbus_port_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
         end else if (start_det) begin
            state_q   <= smbus_port_pkg::ST_ADDR;
            // One below zero: the START's own SCL fall wraps it to zero
            bit_cnt_q <= 4'hF;
            idx_q     <= 8'h00;
            rd_idx_q  <= 8'h00;
            sda_oe_o  <= 1'b0;
         end else if (stop_det) begin
            state_q  <= smbus_port_pkg::ST_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            unique case (state_q)
               smbus_port_pkg::ST_ADDR, smbus_port_pkg::ST_WR: begin
                  if (scl_rise && bit_cnt_q < smbus_port_pkg::BIT_ACK) begin
                     shift_q <= {shift_q[6:0], sda_s};
                  end
                  if (byte_done) begin
                     bit_cnt_q <= smbus_port_pkg::BIT_ACK;
                     if (state_q == smbus_port_pkg::ST_ADDR) begin
                        sda_oe_o <= addr_match;
                        rw_q     <= shift_q[0];
                     end else begin
                        sda_oe_o <= wr_ack;
                     end
                  end else if (scl_fall && bit_cnt_q == smbus_port_pkg::BIT_ACK) begin
                     bit_cnt_q <= 4'h0;
                     if (!sda_oe_o) begin
                        state_q  <= smbus_port_pkg::ST_IGNORE;
                        sda_oe_o <= 1'b0;
                     end else if (state_q == smbus_port_pkg::ST_ADDR && rw_q) begin
                        state_q  <= smbus_port_pkg::ST_RD;
                        tx_q     <= {tx_byte[6:0], 1'b0};
                        sda_oe_o <= ~tx_byte[7];
                     end else begin
                        if (state_q == smbus_port_pkg::ST_WR && idx_q != 8'hFF) begin
                           idx_q <= idx_q + 8'h01;
                        end
                        state_q  <= smbus_port_pkg::ST_WR;
                        sda_oe_o <= 1'b0;
                     end
                  end else if (scl_fall) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end
               end
               smbus_port_pkg::ST_RD: begin
                  if (scl_fall && bit_cnt_q < smbus_port_pkg::BIT_LAST) begin
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     sda_oe_o  <= ~tx_q[7];
                     tx_q      <= {tx_q[6:0], 1'b0};
                  end else if (scl_fall && bit_cnt_q == smbus_port_pkg::BIT_LAST) begin
                     bit_cnt_q <= smbus_port_pkg::BIT_ACK;
                     sda_oe_o  <= 1'b0;
                  end else if (scl_rise && bit_cnt_q == smbus_port_pkg::BIT_ACK) begin
                     // Whole byte out: only now may a clear-on-read fire
                     rd_done_o <= (mode_q == smbus_port_pkg::MODE_REG) || (rd_idx_q != 8'h00) ||
                                  (mode_q == smbus_port_pkg::MODE_NONE);
                     if (sda_s) begin
                        state_q <= smbus_port_pkg::ST_IGNORE;
                     end else if (rd_idx_q != 8'hFF) begin
                        rd_idx_q <= rd_idx_q + 8'h01;
                     end
                  end else if (scl_fall && bit_cnt_q == smbus_port_pkg::BIT_ACK) begin
                     bit_cnt_q <= 4'h0;
                     tx_q      <= {tx_byte[6:0], 1'b0};
                     sda_oe_o  <= ~tx_byte[7];
                  end
               end
               default: sda_oe_o <= 1'b0;
            endcase
         end
      end
   end

   // Read address follows the in-transaction index; the base pointer stays put
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         rd_addr_o <= 8'h00;
         scl_oe_o  <= 1'b0;
         scl_o     <= 1'b0;
         sda_o     <= 1'b0;
      end else begin
         rd_addr_o <= (mode_q == smbus_port_pkg::MODE_REG) ? ptr_q + rd_idx_q :
                      blk_base_q + rd_idx_q - 8'h01;
         scl_oe_o  <= (byte_done && state_q == smbus_port_pkg::ST_WR && push_req) ||
                      (pend_v_q && !fifo_ready);
      end
   end

   property p_timeout_idle;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      tmo_hit |=> (state_q == smbus_port_pkg::ST_IDLE) && !sda_oe_o;
   endproperty
   a_timeout_idle: assert property (p_timeout_idle) else $error("timeout did not idle");

   sequence s_start;
      start_det && !tmo_hit;
   endsequence
   property p_start_restart;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      s_start |=> (state_q == smbus_port_pkg::ST_ADDR) && (bit_cnt_q == 4'hF) && (idx_q == 8'h00);
   endproperty
   a_start_restart: assert property (p_start_restart) else $error("start did not restart");

   property p_abort_no_write;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (start_det || stop_det) && !pend_v_q |=> !pend_v_q;
   endproperty
   a_abort_no_write: assert property (p_abort_no_write) else $error("aborted byte written");

   property p_abort_no_clear;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (start_det || stop_det) |=> !rd_done_o ##1 !rd_done_o;
   endproperty
   a_abort_no_clear: assert property (p_abort_no_clear) else $error("clear after abort");

   property p_reg_range;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      pend_v_q |-> (pend_q.addr <= smbus_port_pkg::REG_LAST);
   endproperty
   a_reg_range: assert property (p_reg_range) else $error("write above register range");

   property p_ptr_fixed_on_read;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_q == smbus_port_pkg::ST_RD) |=> $stable(ptr_q);
   endproperty
   a_ptr_fixed_on_read: assert property (p_ptr_fixed_on_read) else $error("pointer moved on read");

   property p_cmd_ptr;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      cmd_take && (shift_q < smbus_port_pkg::CMD_BLK_WR) |=> (ptr_q == $past(shift_q));
   endproperty
   a_cmd_ptr: assert property (p_cmd_ptr) else $error("pointer not loaded");

   property p_fixed_f9;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      cmd_take && (shift_q == 8'hF9) |=> (blk_base_q == 8'h90) && (blk_len_q == 8'h20);
   endproperty
   a_fixed_f9: assert property (p_fixed_f9) else $error("F9 block wrong");

   property p_fixed_fc;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      cmd_take && (shift_q == 8'hFC) |=> (blk_base_q == 8'hD0) && (blk_len_q == 8'h10);
   endproperty
   a_fixed_fc: assert property (p_fixed_fc) else $error("FC block wrong");

   property p_reserved_nack;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      cmd_take && (shift_q > smbus_port_pkg::CMD_FIX_HI) |=> !sda_oe_o;
   endproperty
   a_reserved_nack: assert property (p_reserved_nack) else $error("reserved code acked");

   property p_addr_kept;
      @(posedge sys_clk_i) disable iff (!rstn_i)
      addr_lat_q |=> addr_lat_q && $stable(own_lsb_q);
   endproperty
   a_addr_kept: assert property (p_addr_kept) else $error("slave address changed");
endmodule
`default_nettype wire
